// [logic/zoom_pkg.sv]
/*
  Constants for the zoom oscillator control block: register offsets,
  control field positions, transfer opcodes and initial values.
  Assumes byte-wide registers reached on even addresses of a 16-bit bus.
*/
package zoom_pkg;
  localparam int COARSE_W = 11;
  localparam int FINE_W = 29;
  localparam int LO_W = COARSE_W + FINE_W;
  localparam int ADDR_W = 8;

  localparam logic [7:0] OFS_COARSE_HI = 8'h30;
  localparam logic [7:0] OFS_COARSE_LO = 8'h32;
  localparam logic [7:0] OFS_FINE_B3 = 8'h34;
  localparam logic [7:0] OFS_FINE_B2 = 8'h36;
  localparam logic [7:0] OFS_FINE_B1 = 8'h38;
  localparam logic [7:0] OFS_FINE_B0 = 8'h3a;
  localparam logic [7:0] OFS_CONTROL = 8'h3c;
  localparam logic [7:0] OFS_STROBE = 8'h3e;

  localparam int CTL_OP_LSB = 0;
  localparam int CTL_OP_MSB = 3;
  localparam int CTL_FILTER = 4;
  localparam int CTL_CLEAR = 6;
  localparam int CTL_RESET = 7;
  localparam logic [7:0] CTL_WR_MASK = 8'hdf;
  localparam logic [7:0] CTL_RESET_VAL = 8'h00;

  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_ST_ALL = 4'h1;
  localparam logic [3:0] OP_RC_FRQ_CRS = 4'h2;
  localparam logic [3:0] OP_RC_PHS_CRS = 4'h3;
  localparam logic [3:0] OP_RC_FRQ_FIN = 4'h4;
  localparam logic [3:0] OP_RC_PHS_FIN = 4'h5;
  localparam logic [3:0] OP_RC_FRQ_BOTH = 4'h6;
  localparam logic [3:0] OP_RC_PHS_BOTH = 4'h7;
  localparam logic [3:0] OP_ST_CRS_BOTH = 4'h8;
  localparam logic [3:0] OP_ST_FIN_BOTH = 4'h9;
  localparam logic [3:0] OP_ST_CRS_FRQ = 4'ha;
  localparam logic [3:0] OP_ST_CRS_PHS = 4'hb;
  localparam logic [3:0] OP_ST_FIN_FRQ = 4'hc;
  localparam logic [3:0] OP_ST_FIN_PHS = 4'hd;
  localparam logic [3:0] OP_ST_BOTH_FRQ = 4'he;
  localparam logic [3:0] OP_ST_BOTH_PHS = 4'hf;

  // Low bits of the byte at 0x32 and of the byte at 0x3a
  localparam int COARSE_LO_SHIFT = 5;
  localparam int FINE_LO_SHIFT = 3;

  localparam logic [COARSE_W-1:0] FREQ_INIT_CRS = 11'h000;
  localparam logic [FINE_W-1:0] FREQ_INIT_FIN = 29'h0000000;
  // 54.77461 in coarse units: integer 54, fraction scaled by 2^29
  localparam logic [COARSE_W-1:0] PHASE_INIT_CRS = 11'h036;
  localparam logic [FINE_W-1:0] PHASE_INIT_FIN = 29'h18c99ae9;
  localparam logic [COARSE_W-1:0] STAGE_INIT_CRS = 11'h000;
  localparam logic [FINE_W-1:0] STAGE_INIT_FIN = 29'h0000000;
endpackage : zoom_pkg

// [logic/zoom_halfband.sv]
/*
  Complex post-mixer lowpass, taps 1-2-1 over 4, per I and Q channel.
  Assumes the sample valid and clear inputs are synchronous to mclk_i.
*/
`timescale 1ns/10ps
module zoom_halfband #(
  parameter int W = 16
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic valid_i,
  input wire logic enable_i,
  input wire logic clear_i,
  input wire logic [W-1:0] in_i_i,
  input wire logic [W-1:0] in_q_i,
  output logic [W-1:0] out_i_o,
  output logic [W-1:0] out_q_o
);
  // Each channel owns its registers, so every variable has one driver
  for (genvar c = 0; c < 2; c++) begin : g_chan
    wire logic [W-1:0] x = (c == 0) ? in_i_i : in_q_i;
    logic [W-1:0] d1;
    logic [W-1:0] d2;
    logic [W-1:0] y;
    wire logic [W+1:0] acc = {{2{x[W-1]}}, x} + {d1[W-1], d1, 1'b0}
      + {{2{d2[W-1]}}, d2};
    // Bypass still advances the delay line so enabling gives no glitch
    wire logic [W-1:0] next_y = enable_i ? acc[W+1:2] : x;
    always_ff @(posedge mclk_i) begin
      if (rst_i || clear_i) begin
        d1 <= '0;
        d2 <= '0;
        y <= '0;
      end else if (valid_i) begin
        d1 <= x;
        d2 <= d1;
        y <= next_y;
      end
    end
  end
  assign out_i_o = g_chan[0].y;
  assign out_q_o = g_chan[1].y;
endmodule : zoom_halfband

// [logic/zoom_oscillator_control.sv]
/*
  Zoom local oscillator control: staging registers, control byte,
  transfer strobe, working frequency and phase, post-mixer lowpass.
  Assumes a byte register port on the low half of a 16-bit data bus,
  and sync, trigger and arm inputs synchronous to mclk_i.
*/
// Contract
// - Control byte: opcode 3..0, filter 4, unused 5, clear 6, reset 7.
// - Opcode transfers happen at a trigger event, not on the control write.
// - Opcode 0 idles; 1 and 8..15 store staging into working registers.
// - Opcodes 2..7 recall working registers into staging registers.
// - Filter bit routes mixer output through 1-2-1 half-band lowpass at the sample rate, else bypass.
// - Clear bit zeroes filter state at next trigger, then clears itself.
// - Reset bit initialises zoom on next sync falling edge only.
// - Init: frequency zero, phase 54.77461, filter off and cleared, control zero.
// - Write to strobe offset starts the transfer; its data is ignored.
// - Strobe transfer runs on the clock cycle after the write.
// - Armed module with a trigger also runs the selected transfer.
// - Coarse staging: bits 10..3 at 0x30, bits 2..0 at 0x32.
// - Fine staging bytes at 0x34, 0x36, 0x38 and 0x3a.
// - Each sample adds working frequency to working phase.
// - Low coarse bits sit in bits 7..5 of 0x32; others read zero.
// - Bits 2..0 of 0x3a read zero and ignore writes.
// - Trigger state with sync pulled low also fires the pending action.
`timescale 1ns/10ps
module zoom_oscillator_control #(
  parameter int SAMPLE_W = 16
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [zoom_pkg::ADDR_W-1:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  input wire logic sync_i,
  input wire logic trigger_state_i,
  input wire logic armed_i,
  input wire logic trigger_i,
  input wire logic sample_valid_i,
  input wire logic [SAMPLE_W-1:0] mix_i_i,
  input wire logic [SAMPLE_W-1:0] mix_q_i,
  output logic [zoom_pkg::LO_W-1:0] lo_phase_o,
  output logic [SAMPLE_W-1:0] zoom_i_o,
  output logic [SAMPLE_W-1:0] zoom_q_o
);
  localparam int CW = zoom_pkg::COARSE_W;
  localparam int FW = zoom_pkg::FINE_W;
  localparam int LW = zoom_pkg::LO_W;

  logic [CW-1:0] stage_crs;
  logic [FW-1:0] stage_fin;
  logic [LW-1:0] freq;
  logic [LW-1:0] phase;
  logic [7:0] control;
  logic strobe_q;
  logic sync_q;

  // Bus decode; upper data byte is ignored on every access
  wire logic [7:0] wbyte = wdata_i[7:0];
  wire logic wr_crs_hi = wr_i && (addr_i == zoom_pkg::OFS_COARSE_HI);
  wire logic wr_crs_lo = wr_i && (addr_i == zoom_pkg::OFS_COARSE_LO);
  wire logic wr_fin_b3 = wr_i && (addr_i == zoom_pkg::OFS_FINE_B3);
  wire logic wr_fin_b2 = wr_i && (addr_i == zoom_pkg::OFS_FINE_B2);
  wire logic wr_fin_b1 = wr_i && (addr_i == zoom_pkg::OFS_FINE_B1);
  wire logic wr_fin_b0 = wr_i && (addr_i == zoom_pkg::OFS_FINE_B0);
  wire logic wr_ctl = wr_i && (addr_i == zoom_pkg::OFS_CONTROL);
  wire logic wr_strobe = wr_i && (addr_i == zoom_pkg::OFS_STROBE);

  // Control fields
  wire logic [3:0] opcode = control[zoom_pkg::CTL_OP_MSB:zoom_pkg::CTL_OP_LSB];
  wire logic filter_en = control[zoom_pkg::CTL_FILTER];
  wire logic clear_req = control[zoom_pkg::CTL_CLEAR];
  wire logic reset_req = control[zoom_pkg::CTL_RESET];

  // Trigger sources
  wire logic sync_fall = sync_q && !sync_i;
  wire logic trig_event = (armed_i && trigger_i)
    || (trigger_state_i && sync_fall);
  wire logic init_go = reset_req && sync_fall;
  wire logic xfer_go = strobe_q || trig_event;
  wire logic clear_go = (clear_req && trig_event) || init_go;

  // Opcode decode into individual moves
  wire logic op_is = (opcode == zoom_pkg::OP_ST_ALL);
  wire logic st_crs_frq = xfer_go && (op_is
    || opcode == zoom_pkg::OP_ST_CRS_BOTH || opcode == zoom_pkg::OP_ST_CRS_FRQ
    || opcode == zoom_pkg::OP_ST_BOTH_FRQ);
  wire logic st_crs_phs = xfer_go && (op_is
    || opcode == zoom_pkg::OP_ST_CRS_BOTH || opcode == zoom_pkg::OP_ST_CRS_PHS
    || opcode == zoom_pkg::OP_ST_BOTH_PHS);
  wire logic st_fin_frq = xfer_go && (op_is
    || opcode == zoom_pkg::OP_ST_FIN_BOTH || opcode == zoom_pkg::OP_ST_FIN_FRQ
    || opcode == zoom_pkg::OP_ST_BOTH_FRQ);
  wire logic st_fin_phs = xfer_go && (op_is
    || opcode == zoom_pkg::OP_ST_FIN_BOTH || opcode == zoom_pkg::OP_ST_FIN_PHS
    || opcode == zoom_pkg::OP_ST_BOTH_PHS);
  wire logic rc_frq_crs = xfer_go && (opcode == zoom_pkg::OP_RC_FRQ_CRS
    || opcode == zoom_pkg::OP_RC_FRQ_BOTH);
  wire logic rc_phs_crs = xfer_go && (opcode == zoom_pkg::OP_RC_PHS_CRS
    || opcode == zoom_pkg::OP_RC_PHS_BOTH);
  wire logic rc_frq_fin = xfer_go && (opcode == zoom_pkg::OP_RC_FRQ_FIN
    || opcode == zoom_pkg::OP_RC_FRQ_BOTH);
  wire logic rc_phs_fin = xfer_go && (opcode == zoom_pkg::OP_RC_PHS_FIN
    || opcode == zoom_pkg::OP_RC_PHS_BOTH);

  // Staging next values; a bus write in the same cycle beats a recall
  wire logic [CW-1:0] crs_recall = rc_frq_crs ? freq[LW-1:FW]
    : rc_phs_crs ? phase[LW-1:FW] : stage_crs;
  wire logic [FW-1:0] fin_recall = rc_frq_fin ? freq[FW-1:0]
    : rc_phs_fin ? phase[FW-1:0] : stage_fin;
  wire logic [CW-1:0] next_crs = wr_crs_hi ? {wbyte, crs_recall[2:0]}
    : wr_crs_lo ? {crs_recall[CW-1:3], wbyte[7:zoom_pkg::COARSE_LO_SHIFT]}
    : crs_recall;
  wire logic [FW-1:0] next_fin = wr_fin_b3 ? {wbyte, fin_recall[20:0]}
    : wr_fin_b2 ? {fin_recall[28:21], wbyte, fin_recall[12:0]}
    : wr_fin_b1 ? {fin_recall[28:13], wbyte, fin_recall[4:0]}
    : wr_fin_b0 ? {fin_recall[28:5], wbyte[7:zoom_pkg::FINE_LO_SHIFT]}
    : fin_recall;

  // Working registers; a store in the same cycle beats the accumulate
  wire logic [LW-1:0] phase_acc = sample_valid_i ? phase + freq : phase;
  wire logic [LW-1:0] next_freq = {st_crs_frq ? stage_crs : freq[LW-1:FW],
    st_fin_frq ? stage_fin : freq[FW-1:0]};
  wire logic [LW-1:0] next_phase = {st_crs_phs ? stage_crs : phase_acc[LW-1:FW],
    st_fin_phs ? stage_fin : phase_acc[FW-1:0]};

  // Control register: a fresh write beats self-clearing and init
  wire logic [7:0] ctl_self = init_go ? zoom_pkg::CTL_RESET_VAL
    : (clear_req && trig_event) ? (control & ~(8'h01 << zoom_pkg::CTL_CLEAR))
    : control;
  wire logic [7:0] next_control = wr_ctl ? (wbyte & zoom_pkg::CTL_WR_MASK)
    : ctl_self;

  // Read mux; write-only and unmapped offsets read zero
  logic [7:0] rbyte;
  always_comb begin
    unique case (addr_i)
      zoom_pkg::OFS_COARSE_HI: rbyte = stage_crs[CW-1:3];
      zoom_pkg::OFS_COARSE_LO: rbyte = {stage_crs[2:0], 5'h00};
      zoom_pkg::OFS_FINE_B3: rbyte = stage_fin[28:21];
      zoom_pkg::OFS_FINE_B2: rbyte = stage_fin[20:13];
      zoom_pkg::OFS_FINE_B1: rbyte = stage_fin[12:5];
      zoom_pkg::OFS_FINE_B0: rbyte = {stage_fin[4:0], 3'h0};
      default: rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      stage_crs <= zoom_pkg::STAGE_INIT_CRS;
      stage_fin <= zoom_pkg::STAGE_INIT_FIN;
    end else begin
      stage_crs <= next_crs;
      stage_fin <= next_fin;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || init_go) begin
      freq <= {zoom_pkg::FREQ_INIT_CRS, zoom_pkg::FREQ_INIT_FIN};
      phase <= {zoom_pkg::PHASE_INIT_CRS, zoom_pkg::PHASE_INIT_FIN};
    end else begin
      freq <= next_freq;
      phase <= next_phase;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      control <= zoom_pkg::CTL_RESET_VAL;
      strobe_q <= 1'b0;
      sync_q <= 1'b1;
      rdata_o <= 16'h0000;
      lo_phase_o <= '0;
    end else begin
      control <= next_control;
      strobe_q <= wr_strobe;
      sync_q <= sync_i;
      rdata_o <= rd_i ? {8'h00, rbyte} : rdata_o;
      lo_phase_o <= phase;
    end
  end

  // Filter state follows the clear moment, not the bit itself
  zoom_halfband #(
    .W(SAMPLE_W)
  ) u_lowpass (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .valid_i(sample_valid_i),
    .enable_i(filter_en),
    .clear_i(clear_go),
    .in_i_i(mix_i_i),
    .in_q_i(mix_q_i),
    .out_i_o(zoom_i_o),
    .out_q_o(zoom_q_o)
  );
endmodule : zoom_oscillator_control

// [bench/zoom_chk.sv]
/* Concurrent checks on the zoom oscillator control ports.
   Assumes one clock, synchronous active-high reset, idle sync high. */
`timescale 1ns/10ps
module zoom_chk (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [zoom_pkg::ADDR_W-1:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic sync_i,
  input wire logic armed_i,
  input wire logic trigger_i,
  input wire logic sample_valid_i,
  input wire logic [zoom_pkg::LO_W-1:0] lo_phase_o
);
  logic sync_prev;
  wire sync_fall = sync_prev && !sync_i;
  wire strobe_wr = wr_i && addr_i == zoom_pkg::OFS_STROBE;
  wire cause = strobe_wr || (armed_i && trigger_i) || sync_fall || sample_valid_i;
  wire unmapped = addr_i < 8'h30 || addr_i > 8'h3e || addr_i[0];
  // Resets high so a low sync at release counts as a fall
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sync_prev <= 1'b1;
    end else begin
      sync_prev <= sync_i;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence rd_req(logic [7:0] a);
    rd_i && addr_i == a;
  endsequence
  // A strobe acts one edge after its write, so it shows one edge later
  a_phase_has_cause: assert property (!$stable(lo_phase_o) |-> $past(cause) ||
    $past(cause, 2) || $past(strobe_wr, 3) || $past(rst_i) || $past(rst_i, 2))
    else $error("phase moved alone");
  a_reset_init_phase: assert property ($fell(rst_i) && !(armed_i && trigger_i) |=>
    lo_phase_o == {zoom_pkg::PHASE_INIT_CRS, zoom_pkg::PHASE_INIT_FIN})
    else $error("phase not initial");
  a_rdata_holds: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved");
  a_coarse_low_mask: assert property (rd_req(8'h32) |=> rdata_o[4:0] == 5'h00)
    else $error("coarse low bits set");
  a_fine_low_mask: assert property (rd_req(8'h3a) |=> rdata_o[2:0] == 3'h0)
    else $error("fine low bits set");
  a_control_reads_zero: assert property (rd_req(8'h3c) |=> rdata_o == 16'h0000)
    else $error("control readable");
  a_strobe_reads_zero: assert property (rd_req(8'h3e) |=> rdata_o == 16'h0000)
    else $error("strobe readable");
  a_unmapped_zero: assert property (rd_i && unmapped |=> rdata_o == 16'h0000)
    else $error("unmapped readable");
endmodule : zoom_chk
bind zoom_oscillator_control zoom_chk chk_u (.mclk_i(mclk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sync_i(sync_i),
  .armed_i(armed_i), .trigger_i(trigger_i), .sample_valid_i(sample_valid_i),
  .lo_phase_o(lo_phase_o));

// [bench/testbench.sv]
/* Self-checking bench for zoom_oscillator_control with a register model.
   Assumes the default sample width of 16 and the bound checker. */
`timescale 1ns/10ps
module testbench;
  logic mclk_i, rst_i, wr_i, rd_i, sync_i, trigger_state_i, armed_i, trigger_i;
  logic sample_valid_i;
  logic [7:0] addr_i;
  logic [15:0] wdata_i, rdata_o, mix_i_i, mix_q_i, zoom_i_o, zoom_q_o, x;
  logic [39:0] lo_phase_o, frq, phs;
  logic [10:0] crs;
  logic [28:0] fin;
  int mismatches, n_checks, cycles;
  int unsigned seed;
  zoom_oscillator_control dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .sync_i(sync_i),
    .trigger_state_i(trigger_state_i), .armed_i(armed_i), .trigger_i(trigger_i),
    .sample_valid_i(sample_valid_i), .mix_i_i(mix_i_i), .mix_q_i(mix_q_i),
    .lo_phase_o(lo_phase_o), .zoom_i_o(zoom_i_o), .zoom_q_o(zoom_q_o));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic see();
    repeat (2) @(negedge mclk_i);
    n_checks++;
    if (lo_phase_o !== phs) begin
      mismatches++;
      $display("BAD phase expected %h seen %h", phs, lo_phase_o);
    end
  endtask : see
  // Upper data byte is junk on purpose: it must be ignored
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    addr_i = a;
    wdata_i = {8'($urandom()), d};
    wr_i = 1'b1;
    @(negedge mclk_i);
    wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge mclk_i);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge mclk_i);
    rd_i = 1'b0;
    @(negedge mclk_i);
    chk_word($sformatf("rd %h", a), e, rdata_o);
  endtask : rd
  task automatic load_stage();
    crs = 11'($urandom());
    fin = 29'($urandom());
    wr(8'h30, crs[10:3]);
    wr(8'h32, {crs[2:0], 5'($urandom())});
    wr(8'h34, fin[28:21]);
    wr(8'h36, fin[20:13]);
    wr(8'h38, fin[12:5]);
    wr(8'h3a, {fin[4:0], 3'($urandom())});
  endtask : load_stage
  task automatic read_stage();
    rd(8'h30, {8'h00, crs[10:3]});
    rd(8'h32, {8'h00, crs[2:0], 5'h00});
    rd(8'h34, {8'h00, fin[28:21]});
    rd(8'h36, {8'h00, fin[20:13]});
    rd(8'h38, {8'h00, fin[12:5]});
    rd(8'h3a, {8'h00, fin[4:0], 3'h0});
  endtask : read_stage
  task automatic apply(input logic [3:0] op);
    case (op)
      4'h1: {frq, phs} = {crs, fin, crs, fin};
      4'h2: crs = frq[39:29];
      4'h3: crs = phs[39:29];
      4'h4: fin = frq[28:0];
      4'h5: fin = phs[28:0];
      4'h6: {crs, fin} = frq;
      4'h7: {crs, fin} = phs;
      4'h8: {frq[39:29], phs[39:29]} = {crs, crs};
      4'h9: {frq[28:0], phs[28:0]} = {fin, fin};
      4'ha: frq[39:29] = crs;
      4'hb: phs[39:29] = crs;
      4'hc: frq[28:0] = fin;
      4'hd: phs[28:0] = fin;
      4'he: frq = {crs, fin};
      4'hf: phs = {crs, fin};
      default: ;
    endcase
  endtask : apply
  task automatic sample();
    @(negedge mclk_i);
    sample_valid_i = 1'b1;
    phs = phs + frq;
    @(negedge mclk_i);
    sample_valid_i = 1'b0;
  endtask : sample
  task automatic trig(input logic arm);
    @(negedge mclk_i);
    armed_i = arm;
    trigger_i = 1'b1;
    @(negedge mclk_i);
    trigger_i = 1'b0;
    armed_i = 1'b0;
  endtask : trig
  task automatic fall();
    @(negedge mclk_i);
    sync_i = 1'b0;
    @(negedge mclk_i);
    sync_i = 1'b1;
  endtask : fall
  task automatic seez(input logic [15:0] e);
    repeat (2) @(negedge mclk_i);
    chk_word("zoom i", e, zoom_i_o);
    chk_word("zoom q", e + 16'h0003, zoom_q_o);
  endtask : seez
  // Hang guard, far above the thousand or so cycles the run needs
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    {rst_i, wr_i, rd_i, trigger_state_i, armed_i, trigger_i, sample_valid_i} = 7'h40;
    {addr_i, wdata_i, mix_i_i, mix_q_i} = '0;
    sync_i = 1'b1;
    seed = $urandom(32'h0580);
    {crs, fin, frq} = '0;
    phs = {zoom_pkg::PHASE_INIT_CRS, zoom_pkg::PHASE_INIT_FIN};
    repeat (8) @(negedge mclk_i);
    rst_i = 1'b0;
    see();
    rd(8'h3c, 16'h0000);
    rd(8'h3e, 16'h0000);
    for (int op = 0; op < 16; op++) begin
      load_stage();
      read_stage();
      wr(8'h3c, {2'b00, 1'($urandom()), 1'b0, 4'(op)});
      see();
      wr(8'h3e, 8'($urandom()));
      apply(4'(op));
      see();
      read_stage();
      sample();
      see();
    end
    load_stage();
    wr(8'h3c, 8'h0f);
    trig(1'b0);
    see();
    trig(1'b1);
    apply(4'hf);
    see();
    load_stage();
    trigger_state_i = 1'b1;
    apply(4'hf);
    fall();
    trigger_state_i = 1'b0;
    see();
    wr(8'h3c, 8'h9e);
    see();
    fall();
    frq = '0;
    phs = {zoom_pkg::PHASE_INIT_CRS, zoom_pkg::PHASE_INIT_FIN};
    see();
    wr(8'h3e, 8'h00);
    sample();
    see();
    x = (16'($urandom()) & 16'h00ff) | 16'h0010;
    {mix_i_i, mix_q_i} = {x, x + 16'h0003};
    repeat (4) sample();
    seez(x);
    wr(8'h3c, 8'h10);
    x = x + 16'h0020;
    {mix_i_i, mix_q_i} = {x, x + 16'h0003};
    repeat (4) sample();
    seez(x);
    wr(8'h3c, 8'h50);
    trig(1'b1);
    {mix_i_i, mix_q_i} = {16'h0000, 16'h0000};
    sample();
    repeat (2) @(negedge mclk_i);
    chk_word("cleared i", 16'h0000, zoom_i_o);
    {mix_i_i, mix_q_i} = {x, x};
    sample();
    trig(1'b1);
    sample();
    repeat (2) @(negedge mclk_i);
    chk_word("self clear", (x + (x << 1)) >> 2, zoom_i_o);
    complete_run();
  end
endmodule : testbench
